// >>> design/fss_ctrl.sv
// Output averaging, timed power-down and status flags of the tilt sensor
`timescale 1ns/1ps
`default_nettype none
`include "fss_params.svh"
module fss_ctrl
  import fss_pkg::*;
#(
  parameter int INCL_W = 14,
  parameter int ADC_W = 12,
  parameter int SUPPLY_LSB_UV = 1000,
  parameter int SLEEP_UNIT_CYC = `FSS_SLEEP_UNIT_CYC,
  parameter int RECOVER_CYC = `FSS_RECOVER_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic [INCL_W-1:0] incl_full_raw,
  input wire logic [INCL_W-1:0] incl_signed_raw,
  input wire logic [ADC_W-1:0] supply_raw,
  input wire logic [ADC_W-1:0] aux_adc_raw,
  input wire logic [ADC_W-1:0] temp_raw,
  input wire logic comm_fail,
  input wire logic selftest_fail,
  input wire logic alarm1_active,
  input wire logic alarm2_active,
  output logic [15:0] tilt_angle_full_circle,
  output logic [15:0] tilt_angle_signed,
  output logic [15:0] supply_out,
  output logic [15:0] aux_adc_out,
  output logic [15:0] temp_out,
  output logic data_ready,
  output logic conv_enable,
  output logic adc_power_down,
  output logic dac_power_down
);
  localparam int DW = 16;
  localparam int NCH = 5;
  localparam int CW = 24;
  localparam logic [ADC_W-1:0] SUP_HI_CODE =
    ADC_W'(`FSS_SUPPLY_HI_MV * 1000 / SUPPLY_LSB_UV);
  localparam logic [ADC_W-1:0] SUP_LO_CODE =
    ADC_W'(`FSS_SUPPLY_LO_MV * 1000 / SUPPLY_LSB_UV);

  // Control and status registers
  logic [3:0] avg_r, avg_nxt;
  logic [7:0] slp_r, slp_nxt;
  fss_word_t stat_r, stat_nxt;
  logic sup_high_r, sup_high_nxt;
  logic sup_low_r, sup_low_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic avg_load;
  logic upd_fail;
  logic clr_stat;

  // Power sequencing state
  fss_pwr_e state_r, state_nxt;
  logic [7:0] unit_r, unit_nxt;
  logic [CW-1:0] cyc_r, cyc_nxt;
  logic wake;
  logic awake;
  logic samp_go;

  // Output registers and filter results
  fss_word_t out_r [NCH];
  fss_word_t out_nxt [NCH];
  logic dr_r, dr_nxt;
  logic signed [DW-1:0] chan_in [NCH];
  logic signed [DW-1:0] fin_d [NCH];
  logic [NCH-1:0] fin_v;
  logic alarm_any;

  // Conversions run only while awake and not recovering
  assign awake = (state_r == FSS_RUN) || (state_r == FSS_PEND);
  assign samp_go = sample_valid && awake;
  assign alarm_any = |stat_r;

  // Raw channels widened to the filter width
  assign chan_in[0] = DW'(incl_full_raw);
  assign chan_in[1] = DW'($signed(incl_signed_raw));
  assign chan_in[2] = DW'(supply_raw);
  assign chan_in[3] = DW'(aux_adc_raw);
  assign chan_in[4] = DW'(temp_raw);

  // Angles pass two cascaded averages, the rest one
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      logic s1_v;
      logic signed [DW-1:0] s1_d;
      fss_avg_stage #(.DW(DW)) u_s1 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .clr(avg_load),
        .taps_log(avg_r),
        .in_valid(samp_go),
        .in_data(chan_in[gi]),
        .out_valid(s1_v),
        .out_data(s1_d)
      );
      if (gi < 2) begin : g_tri
        // Second pass gives the triangular window and double latency
        fss_avg_stage #(.DW(DW)) u_s2 (
          .clk_sys(clk_sys),
          .rst_n(rst_n),
          .ce(ce),
          .clr(avg_load),
          .taps_log(avg_r),
          .in_valid(s1_v),
          .in_data(s1_d),
          .out_valid(fin_v[gi]),
          .out_data(fin_d[gi])
        );
      end else begin : g_single
        assign fin_v[gi] = s1_v;
        assign fin_d[gi] = s1_d;
      end
    end
  endgenerate

  // Register writes, reads and status flags
  always_comb begin
    avg_nxt = avg_r;
    slp_nxt = slp_r;
    stat_nxt = stat_r;
    sup_high_nxt = sup_high_r;
    sup_low_nxt = sup_low_r;
    rdata_nxt = rdata_r;
    avg_load = 1'b0;
    upd_fail = 1'b0;
    clr_stat = 1'b0;
    if (reg_wr) begin
      if (reg_addr == `FSS_ADDR_AVG_LO) begin
        if (reg_wdata[3:0] <= `FSS_AVG_MAX) begin
          avg_nxt = reg_wdata[3:0];
          avg_load = 1'b1;
        end else begin
          upd_fail = 1'b1;
        end
      end else if (reg_addr == `FSS_ADDR_SLP_LO) begin
        if (awake) begin
          slp_nxt = reg_wdata;
        end
      end else if (reg_addr == `FSS_ADDR_CMD_LO) begin
        clr_stat = reg_wdata[`FSS_CMD_CLR_STAT_BIT];
      end
    end
    if (wake) begin
      slp_nxt = `FSS_SLP_RESET;
    end
    // Supply checked on every accepted sample
    if (samp_go) begin
      sup_high_nxt = supply_raw > SUP_HI_CODE;
      sup_low_nxt = supply_raw < SUP_LO_CODE;
    end
    if (clr_stat) begin
      stat_nxt = `FSS_STAT_RESET;
    end
    // Set after clear, so a live condition wins
    stat_nxt[`FSS_ST_UPD_FAIL_BIT] = stat_nxt[`FSS_ST_UPD_FAIL_BIT] | upd_fail;
    stat_nxt[`FSS_ST_COMM_BIT] = stat_nxt[`FSS_ST_COMM_BIT] | comm_fail;
    stat_nxt[`FSS_ST_SELFTEST_BIT] = stat_nxt[`FSS_ST_SELFTEST_BIT] | selftest_fail;
    stat_nxt[`FSS_ST_ALM1_BIT] = stat_nxt[`FSS_ST_ALM1_BIT] | alarm1_active;
    stat_nxt[`FSS_ST_ALM2_BIT] = stat_nxt[`FSS_ST_ALM2_BIT] | alarm2_active;
    // Supply flags follow the condition and drop once in range
    stat_nxt[`FSS_ST_OVER_BIT] = sup_high_r;
    stat_nxt[`FSS_ST_UNDER_BIT] = sup_low_r;
    // Byte reads; unused bits and unmapped bytes read zero
    if (reg_rd) begin
      if (reg_addr == `FSS_ADDR_AVG_LO) begin
        rdata_nxt = {4'h0, avg_r};
      end else if (reg_addr == `FSS_ADDR_SLP_LO) begin
        rdata_nxt = slp_r;
      end else if (reg_addr == `FSS_ADDR_STAT_LO) begin
        rdata_nxt = stat_r[7:0];
      end else if (reg_addr == `FSS_ADDR_STAT_HI) begin
        rdata_nxt = stat_r[15:8];
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      avg_r <= `FSS_AVG_RESET;
      slp_r <= `FSS_SLP_RESET;
      stat_r <= `FSS_STAT_RESET;
      sup_high_r <= 1'b0;
      sup_low_r <= 1'b0;
      rdata_r <= 8'h00;
    end else if (ce) begin
      avg_r <= avg_nxt;
      slp_r <= slp_nxt;
      stat_r <= stat_nxt;
      sup_high_r <= sup_high_nxt;
      sup_low_r <= sup_low_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Power-down sequencer and sleep timer
  always_comb begin
    state_nxt = state_r;
    unit_nxt = unit_r;
    cyc_nxt = cyc_r;
    wake = 1'b0;
    case (state_r)
      FSS_RUN: begin
        if (slp_r != 8'h00) begin
          state_nxt = FSS_PEND;
        end
      end
      FSS_PEND: begin
        if (slp_r == 8'h00) begin
          state_nxt = FSS_RUN;
        end else if (fin_v[0]) begin
          state_nxt = FSS_DROP;
        end
      end
      FSS_DROP: begin
        state_nxt = FSS_SLEEP;
        unit_nxt = slp_r;
        cyc_nxt = CW'(SLEEP_UNIT_CYC - 1);
      end
      FSS_SLEEP: begin
        if (cyc_r != '0) begin
          cyc_nxt = cyc_r - 1'b1;
        end else if (unit_r > 8'h01) begin
          unit_nxt = unit_r - 8'h01;
          cyc_nxt = CW'(SLEEP_UNIT_CYC - 1);
        end else begin
          state_nxt = FSS_RECOVER;
          cyc_nxt = CW'(RECOVER_CYC - 1);
          wake = 1'b1;
        end
      end
      FSS_RECOVER: begin
        if (cyc_r != '0) begin
          cyc_nxt = cyc_r - 1'b1;
        end else begin
          state_nxt = FSS_RUN;
        end
      end
      default: begin
        state_nxt = FSS_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= FSS_RUN;
      unit_r <= 8'h00;
      cyc_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      unit_r <= unit_nxt;
      cyc_r <= cyc_nxt;
    end
  end

  // Data output registers and data-ready line
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      out_nxt[c] = out_r[c];
      if (fin_v[c]) begin
        out_nxt[c][`FSS_DATA_W-1:0] = fin_d[c][`FSS_DATA_W-1:0];
        out_nxt[c][`FSS_DATA_ND_BIT] = 1'b1;
      end
      out_nxt[c][`FSS_DATA_ALM_BIT] = alarm_any;
      if (state_r == FSS_DROP) begin
        out_nxt[c][`FSS_DATA_ND_BIT] = 1'b0;
      end
    end
    dr_nxt = dr_r;
    if (fin_v[0]) begin
      dr_nxt = 1'b1;
    end
    // Dropped as the next conversion starts, and before sleeping
    if (samp_go || state_r == FSS_DROP) begin
      dr_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        out_r[c] <= 16'h0000;
      end
      dr_r <= 1'b0;
    end else if (ce) begin
      for (int c = 0; c < NCH; c++) begin
        out_r[c] <= out_nxt[c];
      end
      dr_r <= dr_nxt;
    end
  end

  // Port drive
  assign tilt_angle_full_circle = out_r[0];
  assign tilt_angle_signed = out_r[1];
  assign supply_out = out_r[2];
  assign aux_adc_out = out_r[3];
  assign temp_out = out_r[4];
  assign reg_rdata = rdata_r;
  assign data_ready = dr_r;
  assign conv_enable = awake;
  assign adc_power_down = (state_r == FSS_SLEEP);
  assign dac_power_down = (state_r == FSS_SLEEP);
endmodule
`default_nettype wire

// >>> shared/fss_params.svh
// Offsets, field positions, reset values and timing counts
`ifndef FSS_PARAMS_SVH
`define FSS_PARAMS_SVH

`define FSS_ADDR_AVG_LO 6'h38
`define FSS_ADDR_AVG_HI 6'h39
`define FSS_ADDR_SLP_LO 6'h3A
`define FSS_ADDR_SLP_HI 6'h3B
`define FSS_ADDR_STAT_LO 6'h3C
`define FSS_ADDR_STAT_HI 6'h3D
`define FSS_ADDR_CMD_LO 6'h3E

`define FSS_AVG_RESET 4'h7
`define FSS_SLP_RESET 8'h00
`define FSS_STAT_RESET 16'h0000
`define FSS_AVG_MAX 4'h8

`define FSS_CMD_CLR_STAT_BIT 4
`define FSS_ST_UNDER_BIT 0
`define FSS_ST_OVER_BIT 1
`define FSS_ST_UPD_FAIL_BIT 2
`define FSS_ST_COMM_BIT 3
`define FSS_ST_SELFTEST_BIT 5
`define FSS_ST_ALM1_BIT 8
`define FSS_ST_ALM2_BIT 9
`define FSS_DATA_ND_BIT 15
`define FSS_DATA_ALM_BIT 14
`define FSS_DATA_W 14

`define FSS_SUPPLY_HI_MV 3625
`define FSS_SUPPLY_LO_MV 2975

`define FSS_CLK_PERIOD_NS 50
`define FSS_SLEEP_UNIT_NS 500000000
`define FSS_RECOVER_NS 2000000
`define FSS_SLEEP_UNIT_CYC (`FSS_SLEEP_UNIT_NS / `FSS_CLK_PERIOD_NS)
`define FSS_RECOVER_CYC ((`FSS_RECOVER_NS + `FSS_CLK_PERIOD_NS - 1) / `FSS_CLK_PERIOD_NS)

`endif

// >>> shared/fss_pkg.sv
// Types shared by the filter, sleep and status control
package fss_pkg;
  typedef enum logic [2:0] {
    FSS_RUN = 3'b000,
    FSS_PEND = 3'b001,
    FSS_DROP = 3'b010,
    FSS_SLEEP = 3'b011,
    FSS_RECOVER = 3'b100
  } fss_pwr_e;
  typedef logic [15:0] fss_word_t;
endpackage

// >>> design/fss_avg_stage.sv
// One moving-average stage with a power-of-two tap count
`timescale 1ns/1ps
`default_nettype none
module fss_avg_stage #(
  parameter int DW = 16,
  parameter int LOG_MAX = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clr,
  input wire logic [3:0] taps_log,
  input wire logic in_valid,
  input wire logic signed [DW-1:0] in_data,
  output logic out_valid,
  output logic signed [DW-1:0] out_data
);
  localparam int DEPTH = 1 << LOG_MAX;
  localparam int SW = DW + LOG_MAX + 1;

  logic signed [DW-1:0] hist [DEPTH];
  logic [LOG_MAX-1:0] wr_ptr_r, wr_ptr_nxt;
  logic [LOG_MAX:0] fill_r, fill_nxt;
  logic signed [SW-1:0] sum_r, sum_nxt;
  logic out_valid_r, out_valid_nxt;
  logic signed [DW-1:0] out_data_r, out_data_nxt;
  logic [LOG_MAX:0] taps;
  logic [LOG_MAX-1:0] old_idx;
  logic signed [DW-1:0] old_val;

  // Oldest sample leaving the window; zero until the window has filled
  assign taps = (LOG_MAX + 1)'(1) << taps_log;
  assign old_idx = wr_ptr_r - taps[LOG_MAX-1:0];
  assign old_val = (fill_r >= taps) ? hist[old_idx] : '0;

  // Running sum, scaled by the tap count on output
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    fill_nxt = fill_r;
    sum_nxt = sum_r;
    out_valid_nxt = 1'b0;
    out_data_nxt = out_data_r;
    if (clr) begin
      wr_ptr_nxt = '0;
      fill_nxt = '0;
      sum_nxt = '0;
    end else if (in_valid) begin
      sum_nxt = sum_r + SW'(in_data) - SW'(old_val);
      wr_ptr_nxt = wr_ptr_r + 1'b1;
      if (fill_r != (LOG_MAX + 1)'(DEPTH)) begin
        fill_nxt = fill_r + 1'b1;
      end
      out_valid_nxt = 1'b1;
      out_data_nxt = DW'(sum_nxt >>> taps_log);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      fill_r <= '0;
      sum_r <= '0;
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else if (ce) begin
      wr_ptr_r <= wr_ptr_nxt;
      fill_r <= fill_nxt;
      sum_r <= sum_nxt;
      out_valid_r <= out_valid_nxt;
      out_data_r <= out_data_nxt;
    end
  end

  // History store, written only while running
  always_ff @(posedge clk_sys) begin
    if (ce && in_valid && !clr) begin
      hist[wr_ptr_r] <= in_data;
    end
  end

  assign out_valid = out_valid_r;
  assign out_data = out_data_r;
endmodule
`default_nettype wire

// >>> tb/fss_ctrl_properties.sv
// Checker for the filter, sleep and status control
`timescale 1ns/1ps
`default_nettype none
`include "fss_params.svh"
module fss_ctrl_properties
  import fss_pkg::*;
#(
  parameter int SLEEP_UNIT_CYC = 20,
  parameter int RECOVER_CYC = 5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [15:0] tilt_angle_full_circle,
  input wire logic [15:0] tilt_angle_signed,
  input wire logic [15:0] supply_out,
  input wire logic [15:0] aux_adc_out,
  input wire logic [15:0] temp_out,
  input wire logic data_ready,
  input wire logic conv_enable,
  input wire logic adc_power_down,
  input wire logic dac_power_down
);
  logic [31:0] sleep_duration_count_r, sleep_duration_count_nxt, off_cnt_r, off_cnt_nxt;
  logic [7:0] slp_val_r, slp_val_nxt;
  // Sleep length, recovery length and last accepted sleep code
  always_comb begin
    sleep_duration_count_nxt = adc_power_down ? sleep_duration_count_r + 32'h1 : 32'h0;
    off_cnt_nxt = (!conv_enable && !adc_power_down) ? off_cnt_r + 32'h1 : 32'h0;
    slp_val_nxt = slp_val_r;
    if (reg_wr && reg_addr == `FSS_ADDR_SLP_LO && conv_enable) begin
      slp_val_nxt = reg_wdata;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sleep_duration_count_r <= 32'h0;
      off_cnt_r <= 32'h0;
      slp_val_r <= 8'h00;
    end else begin
      sleep_duration_count_r <= sleep_duration_count_nxt;
      off_cnt_r <= off_cnt_nxt;
      slp_val_r <= slp_val_nxt;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_dac_down: assert property (adc_power_down |-> dac_power_down && !conv_enable)
    else $error("converter awake during sleep");
  chk_ready_idle: assert property (dac_power_down |-> !data_ready)
    else $error("data ready high in sleep");
  chk_nd_clear: assert property ($rose(adc_power_down) |-> !(tilt_angle_full_circle[15]
    || tilt_angle_signed[15] || supply_out[15] || aux_adc_out[15] || temp_out[15]))
    else $error("new data bit kept into sleep");
  chk_data_hold: assert property (adc_power_down && $past(adc_power_down) |->
    $stable(tilt_angle_full_circle[13:0]) && $stable(aux_adc_out[13:0]))
    else $error("outputs changed in sleep");
  chk_alarm_same: assert property (supply_out[14] == tilt_angle_full_circle[14]
    && temp_out[14] == aux_adc_out[14] && tilt_angle_signed[14] == supply_out[14])
    else $error("alarm bits disagree");
  chk_sleep_len: assert property ($fell(adc_power_down) |->
    sleep_duration_count_r == 32'(slp_val_r) * 32'(SLEEP_UNIT_CYC))
    else $error("sleep length wrong");
  // Only a timed wake runs the recovery wait; a reset wake skips it
  chk_recover_len: assert property ($rose(conv_enable) && !$past(adc_power_down) |->
    off_cnt_r == RECOVER_CYC)
    else $error("recovery length wrong");
  chk_avg_limit: assert property (reg_rd && reg_addr == `FSS_ADDR_AVG_LO |=>
    reg_rdata <= 8'h08)
    else $error("averaging code above eight");
  chk_sleep_after: assert property ($rose(adc_power_down) |->
    $past(data_ready) || $past(data_ready, 2))
    else $error("sleep without final update");
  cov_sleep: cover property ($fell(adc_power_down));
  cov_wake: cover property ($rose(conv_enable));
  cov_status: cover property (reg_rd && reg_addr == `FSS_ADDR_STAT_LO);
endmodule
bind fss_ctrl fss_ctrl_properties #(
  .SLEEP_UNIT_CYC(SLEEP_UNIT_CYC),
  .RECOVER_CYC(RECOVER_CYC)
) chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .tilt_angle_full_circle(tilt_angle_full_circle), .tilt_angle_signed(tilt_angle_signed),
  .supply_out(supply_out), .aux_adc_out(aux_adc_out), .temp_out(temp_out),
  .data_ready(data_ready), .conv_enable(conv_enable),
  .adc_power_down(adc_power_down), .dac_power_down(dac_power_down)
);
`default_nettype wire

// >>> tb/fss_host_model.sv
// Host processor model driving the byte register port
`timescale 1ns/1ps
`default_nettype none
module fss_host_model (
  input wire logic clk_sys,
  output logic [5:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // Idle bus
  initial begin
    reg_addr = 6'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Byte write; callers keep averaging codes at or below eight unless testing refusal
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Byte read, data taken one edge after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> tb/fss_ctrl_tb.sv
// Self-checking bench for the filter, sleep and status control
`timescale 1ns/1ps
`default_nettype none
module fss_ctrl_tb
  import fss_pkg::*;
;
  logic clk_sys, rst_n, ce, sample_valid, reg_wr, reg_rd, data_ready, conv_enable;
  logic comm_fail, selftest_fail, alarm1_active, alarm2_active;
  logic adc_power_down, dac_power_down;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, lo, hi;
  logic [13:0] incl_full_raw, incl_signed_raw;
  logic [11:0] supply_raw, aux_adc_raw, temp_raw;
  fss_word_t tilt_angle_full_circle, tilt_angle_signed, supply_out, aux_adc_out, temp_out;
  fss_word_t sup2, ang2, snap;
  fss_word_t stat_tbl[4] = '{16'h0008, 16'h0020, 16'h0100, 16'h0200};
  int n_fail = 0;
  int compares = 0;
  int n;
  // Clock at 50 ns
  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;
  fss_ctrl #(.SLEEP_UNIT_CYC(20), .RECOVER_CYC(5)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .incl_full_raw(incl_full_raw),
    .incl_signed_raw(incl_signed_raw), .supply_raw(supply_raw),
    .aux_adc_raw(aux_adc_raw), .temp_raw(temp_raw), .comm_fail(comm_fail),
    .selftest_fail(selftest_fail), .alarm1_active(alarm1_active),
    .alarm2_active(alarm2_active), .tilt_angle_full_circle(tilt_angle_full_circle),
    .tilt_angle_signed(tilt_angle_signed), .supply_out(supply_out),
    .aux_adc_out(aux_adc_out), .temp_out(temp_out), .data_ready(data_ready),
    .conv_enable(conv_enable), .adc_power_down(adc_power_down),
    .dac_power_down(dac_power_down)
  );
  fss_host_model host_u (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );
  // Verdict and end of run
  task automatic summarize;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Compare and count
  task automatic chk(input fss_word_t got, input fss_word_t exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Register byte read and compare
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    host_u.rd(a, lo);
    chk({8'h00, lo}, {8'h00, e});
  endtask
  // Bounded wait on power-down or conversion enable
  task automatic wait_lvl(input logic conv, input logic lvl);
    n = 0;
    while ((conv ? conv_enable : adc_power_down) !== lvl) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > 9000) begin
        n_fail++;
        summarize();
      end
    end
  endtask
  // One sample; outputs grabbed one and two edges after it is taken
  task automatic smp(input logic [13:0] ang, input logic [11:0] sup, input logic [11:0] aux);
    @(posedge clk_sys);
    incl_full_raw <= ang;
    incl_signed_raw <= ang;
    supply_raw <= sup;
    aux_adc_raw <= aux;
    temp_raw <= aux;
    sample_valid <= 1'b1;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    @(posedge clk_sys);
    #1;
    sup2 = aux_adc_out;
    ang2 = tilt_angle_full_circle;
    @(posedge clk_sys);
    #1;
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    sample_valid = 1'b0;
    {incl_full_raw, incl_signed_raw} = 28'h0;
    {supply_raw, aux_adc_raw, temp_raw} = {12'hCE4, 24'h0};
    {alarm2_active, alarm1_active, selftest_fail, comm_fail} = 4'h0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk(6'h38, 8'h07);
    rchk(6'h3A, 8'h00);
    rchk(6'h3C, 8'h00);
    rchk(6'h3D, 8'h00);
    host_u.wr(6'h38, 8'h09);
    rchk(6'h38, 8'h07);
    rchk(6'h3C, 8'h04);
    host_u.wr(6'h3C, 8'hFF);
    rchk(6'h3C, 8'h04);
    host_u.wr(6'h3E, 8'h10);
    rchk(6'h3C, 8'h00);
    host_u.wr(6'h38, 8'h01);
    smp(14'h190, 12'hCE4, 12'h190);
    chk(sup2, 16'h80C8);
    chk(ang2, 16'h0000);
    chk(tilt_angle_full_circle, 16'h8064);
    chk(supply_out, 16'h8672);
    chk(temp_out, 16'h80C8);
    chk(tilt_angle_signed, 16'h8064);
    chk({15'h0, data_ready}, 16'h0001);
    smp(14'h320, 12'hCE4, 12'h320);
    chk(sup2, 16'h8258);
    chk(ang2, 16'h8064);
    chk(tilt_angle_full_circle, 16'h8190);
    smp(14'h190, 12'hE74, 12'h190);
    rchk(6'h3C, 8'h02);
    chk({15'h0, tilt_angle_full_circle[14]}, 16'h0001);
    smp(14'h190, 12'hB54, 12'h190);
    rchk(6'h3C, 8'h01);
    smp(14'h190, 12'hCE4, 12'h190);
    rchk(6'h3C, 8'h00);
    // Single tap passes the sample through; top code eight is accepted
    host_u.wr(6'h38, 8'h00);
    smp(14'h190, 12'hCE4, 12'h190);
    chk(aux_adc_out, 16'h8190);
    host_u.wr(6'h38, 8'h08);
    rchk(6'h38, 8'h08);
    host_u.wr(6'h38, 8'h01);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      {alarm2_active, alarm1_active, selftest_fail, comm_fail} <= 4'h1 << i;
      @(posedge clk_sys);
      {alarm2_active, alarm1_active, selftest_fail, comm_fail} <= 4'h0;
      host_u.rd(6'h3C, lo);
      host_u.rd(6'h3D, hi);
      chk({hi, lo}, stat_tbl[i]);
      host_u.wr(6'h3E, 8'h10);
    end
    comm_fail <= 1'b1;
    host_u.wr(6'h3E, 8'h10);
    rchk(6'h3C, 8'h08);
    comm_fail <= 1'b0;
    host_u.wr(6'h3E, 8'h10);
    host_u.wr(6'h3A, 8'h02);
    rchk(6'h3A, 8'h02);
    repeat (10) @(posedge clk_sys);
    chk({15'h0, adc_power_down}, 16'h0000);
    smp(14'h320, 12'hCE4, 12'h320);
    wait_lvl(1'b0, 1'b1);
    #1;
    chk({14'h0, data_ready, tilt_angle_full_circle[15]}, 16'h0000);
    chk({15'h0, dac_power_down}, 16'h0001);
    snap = tilt_angle_full_circle;
    smp(14'h3FF, 12'hCE4, 12'h3FF);
    wait_lvl(1'b0, 1'b0);
    chk(tilt_angle_full_circle, snap);
    rchk(6'h3A, 8'h00);
    rchk(6'h38, 8'h01);
    wait_lvl(1'b1, 1'b1);
    host_u.wr(6'h3A, 8'hFF);
    smp(14'h190, 12'hCE4, 12'h190);
    wait_lvl(1'b0, 1'b1);
    repeat (30) @(posedge clk_sys);
    chk({15'h0, adc_power_down}, 16'h0001);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({15'h0, adc_power_down}, 16'h0000);
    rchk(6'h3A, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
